// ---- verilog/bstx_pkg.sv ----
package bstx_pkg;

    // Widths of the core datapaths
    localparam int DATA_W = 8;
    localparam int DADDR_W = 8;
    localparam int PADDR_W = 16;
    localparam int PWORD_W = 16;
    localparam int BITSEL_W = 3;

    // Register reset values and the last program page
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TBL_RST = 8'h00;
    localparam logic [7:0] LAST_PAGE = 8'hff;

    // Status flag layout
    localparam int ZERO_BIT = 2;
    localparam int FLAGS_W = 8;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Register port offsets
    localparam logic [7:0] OFF_ACC = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h01;
    localparam logic [7:0] OFF_TPL = 8'h02;
    localparam logic [7:0] OFF_TPH = 8'h03;
    localparam logic [7:0] OFF_TBH = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h05;

    // Operation selector
    typedef enum logic [2:0] {
        BSTX_NOP,
        BSTX_BIT_ZERO_SKIP_OP,
        BSTX_TABLE_READ_OP,
        BSTX_LAST_PAGE_TABLE_READ_OP,
        BSTX_XOR_REG_OP,
        BSTX_XOR_TO_MEMORY_OP,
        BSTX_XOR_IMM_OP
    } bstx_op_t;

    // Issued instruction
    typedef struct packed {
        logic                valid;
        bstx_op_t            op;
        logic [DADDR_W-1:0]  addr;
        logic [BITSEL_W-1:0] bit_sel;
        logic [DATA_W-1:0]   imm;
    } bstx_instr_t;

    // Data memory write
    typedef struct packed {
        logic               we;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } bstx_dwr_t;

    // Sequencer states
    typedef enum logic [1:0] {
        BSTX_IDLE,
        BSTX_TBL_WAIT,
        BSTX_DUMMY
    } bstx_state_t;

endpackage : bstx_pkg

// ---- verilog/bstx_core.sv ----
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Operation
// (RULE_01) Bit-test skip: selected memory bit zero skips next instruction; flags untouched.
// (RULE_02) Skip takes two cycles; a dummy cycle is inserted during refetch.
// (RULE_03) Table read fetches word at high:low pointer; low to memory, high to latch.
// (RULE_04) Last-page table read uses only low pointer on last program page.
// (RULE_05) Register XOR: accumulator gets accumulator xor memory byte; zero flag only.
// (RULE_06) Memory XOR: result written back to memory location; zero flag only.
// (RULE_07) Immediate XOR: accumulator gets accumulator xor immediate; zero flag only.
// (RULE_08) Zero flag set when XOR result is zero, cleared otherwise; others kept.
module bstx_core (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Instruction issue
    input  wire bstx_pkg::bstx_instr_t       instr,
    output logic                             instr_ready,
    output logic                             skip_next,
    output logic                             dummy_cycle,
    // Data memory: read is combinational at dmem_raddr
    output logic [bstx_pkg::DADDR_W-1:0]     dmem_raddr,
    input  wire logic [bstx_pkg::DATA_W-1:0] dmem_rdata,
    output bstx_pkg::bstx_dwr_t              dmem_wr,
    // Program memory: data in the same cycle as the request
    output logic                             pmem_req,
    output logic [bstx_pkg::PADDR_W-1:0]     pmem_addr,
    input  wire logic [bstx_pkg::PWORD_W-1:0] pmem_rdata,
    // Register port
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata
);
    import bstx_pkg::*;

    // All block state lives in one packed record
    typedef struct packed {
        bstx_state_t          state;
        logic [DATA_W-1:0]    accumulator;
        logic [FLAGS_W-1:0]   flags;
        logic [DATA_W-1:0]    table_pointer_low;
        logic [DATA_W-1:0]    table_pointer_high;
        logic [DATA_W-1:0]    table_high_latch;
        logic [DADDR_W-1:0]   tbl_dest;
        logic                 skip_next;
        logic                 dummy_cycle;
        logic                 pmem_req;
        logic [PADDR_W-1:0]   pmem_addr;
        bstx_dwr_t            dmem_wr;
        logic [7:0]           reg_rdata;
    } bstx_regs_t;

    bstx_regs_t r;
    bstx_regs_t next_r;

    // Xor and zero test shared by the three forms
    function automatic logic [DATA_W:0] xor_z(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        logic [DATA_W-1:0] res;
        res = a ^ b;
        return {res == '0, res};
    endfunction : xor_z

    // Xor forms that end in the accumulator; shared by any_xor and write priority
    function automatic logic acc_xor(input bstx_op_t op);
        return (op == BSTX_XOR_REG_OP) || (op == BSTX_XOR_IMM_OP);
    endfunction : acc_xor

    // Any xor form; the only instructions that touch the flags
    function automatic logic any_xor(input bstx_op_t op);
        return acc_xor(op) || (op == BSTX_XOR_TO_MEMORY_OP);
    endfunction : any_xor

    // Software view of the registers; unmapped offsets read zero
    function automatic logic [7:0] reg_view(input logic [7:0] a, input bstx_regs_t s);
        logic [7:0] v;
        case (a)
            OFF_ACC:   v = s.accumulator;
            OFF_FLAGS: v = s.flags;
            OFF_TPL:   v = s.table_pointer_low;
            OFF_TPH:   v = s.table_pointer_high;
            OFF_TBH:   v = s.table_high_latch;
            OFF_STAT:  v = {6'h00, s.state};
            default:   v = 8'h00;
        endcase
        return v;
    endfunction : reg_view

    // Xor result with the zero test in its top bit
    logic [DATA_W:0] xr;
    logic            take;

    // New work is only accepted when no table fetch or dummy cycle is pending
    // Refused work simply waits; the issuer holds it until instr_ready returns
    assign instr_ready = (r.state == BSTX_IDLE);
    assign take        = instr.valid && instr_ready;
    assign dmem_raddr  = instr.addr;
    assign skip_next   = r.skip_next;
    assign dummy_cycle = r.dummy_cycle;
    assign dmem_wr     = r.dmem_wr;
    assign pmem_req    = r.pmem_req;
    assign pmem_addr   = r.pmem_addr;
    assign reg_rdata   = r.reg_rdata;

    // Next-state logic
    always_comb begin
        // Hold all state; every strobe drops so that it stands one cycle only
        next_r             = r;
        next_r.skip_next   = 1'b0;
        next_r.dummy_cycle = 1'b0;
        next_r.pmem_req    = 1'b0;
        next_r.dmem_wr.we  = 1'b0;
        next_r.reg_rdata   = 8'h00;
        // Only the immediate form bypasses the data memory operand
        xr = xor_z(r.accumulator, (instr.op == BSTX_XOR_IMM_OP) ? instr.imm : dmem_rdata);

        case (r.state)
            BSTX_IDLE: begin
                if (take) begin
                    case (instr.op)
                        BSTX_BIT_ZERO_SKIP_OP: begin
                            // A one in the tested bit falls through untouched
                            // (RULE_01) Bit zero skips
                            if (!dmem_rdata[instr.bit_sel]) begin
                                next_r.skip_next   = 1'b1;
                                // (RULE_02) Insert dummy cycle
                                next_r.dummy_cycle = 1'b1;
                                next_r.state       = BSTX_DUMMY;
                            end
                        end
                        BSTX_TABLE_READ_OP: begin
                            // (RULE_03) Full pointer fetch
                            next_r.pmem_req  = 1'b1;
                            next_r.pmem_addr = {r.table_pointer_high, r.table_pointer_low};
                            next_r.tbl_dest  = instr.addr;
                            next_r.state     = BSTX_TBL_WAIT;
                        end
                        BSTX_LAST_PAGE_TABLE_READ_OP: begin
                            // (RULE_04) Last page, low pointer
                            // The high pointer is ignored here on purpose
                            next_r.pmem_req  = 1'b1;
                            next_r.pmem_addr = {LAST_PAGE, r.table_pointer_low};
                            next_r.tbl_dest  = instr.addr;
                            next_r.state     = BSTX_TBL_WAIT;
                        end
                        BSTX_XOR_REG_OP, BSTX_XOR_IMM_OP: begin
                            // (RULE_05) Result to accumulator
                            // (RULE_07) Immediate operand form
                            next_r.accumulator     = xr[DATA_W-1:0];
                            // (RULE_08) Zero flag only
                            next_r.flags[ZERO_BIT] = xr[DATA_W];
                        end
                        BSTX_XOR_TO_MEMORY_OP: begin
                            // (RULE_06) Result back to memory
                            // Accumulator keeps its value; the write lands next cycle
                            next_r.dmem_wr.we      = 1'b1;
                            next_r.dmem_wr.addr    = instr.addr;
                            next_r.dmem_wr.data    = xr[DATA_W-1:0];
                            // (RULE_08) Zero flag only
                            next_r.flags[ZERO_BIT] = xr[DATA_W];
                        end
                        default: begin
                            // No-operation slot: nothing changes
                        end
                    endcase
                end
            end
            BSTX_TBL_WAIT: begin
                // (RULE_03) Low byte to memory, high to latch
                // The word arrives in the same cycle as the request; flags stay as they were
                next_r.dmem_wr.we        = 1'b1;
                next_r.dmem_wr.addr      = r.tbl_dest;
                next_r.dmem_wr.data      = pmem_rdata[7:0];
                next_r.table_high_latch  = pmem_rdata[15:8];
                next_r.state             = BSTX_IDLE;
            end
            BSTX_DUMMY: begin
                // Second cycle of the skip; the discarded fetch retires here
                next_r.state = BSTX_IDLE;
            end
            default: begin
                next_r.state = BSTX_IDLE;
            end
        endcase

        // Software writes; a same-cycle core update takes priority
        // Latch and status offsets are read-only and fall to the default arm
        if (reg_wr) begin
            case (reg_addr)
                OFF_ACC: begin
                    if (!(take && acc_xor(instr.op)))
                        next_r.accumulator = reg_wdata;
                end
                OFF_FLAGS: begin
                    if (!(take && any_xor(instr.op)))
                        next_r.flags = reg_wdata;
                end
                OFF_TPL: next_r.table_pointer_low  = reg_wdata;
                OFF_TPH: next_r.table_pointer_high = reg_wdata;
                default: begin
                end
            endcase
        end

        // Read data one cycle after the strobe; unmapped reads zero
        if (reg_rd) begin
            next_r.reg_rdata = reg_view(reg_addr, r);
        end
    end

    // State register
    // Asynchronous clear puts every field back to its reset constant
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r                    <= '0;
            r.state              <= BSTX_IDLE;
            r.accumulator        <= ACC_RST;
            r.flags              <= FLAGS_RST;
            r.table_pointer_low  <= TBL_RST;
            r.table_pointer_high <= TBL_RST;
            r.table_high_latch   <= TBL_RST;
        end else begin
            r <= next_r;
        end
    end

endmodule : bstx_core

// ---- bench/bstx_chk.sv ----
`timescale 1ns/10ps
module bstx_chk (
    // Clock and reset
    input wire logic                          sys_clk,
    input wire logic                          rst,
    // Watched ports
    input wire bstx_pkg::bstx_instr_t         instr,
    input wire logic                          instr_ready,
    input wire logic                          skip_next,
    input wire logic                          dummy_cycle,
    input wire logic [bstx_pkg::DADDR_W-1:0]  dmem_raddr,
    input wire logic [bstx_pkg::DATA_W-1:0]   dmem_rdata,
    input wire bstx_pkg::bstx_dwr_t           dmem_wr,
    input wire logic                          pmem_req,
    input wire logic [bstx_pkg::PADDR_W-1:0]  pmem_addr,
    input wire logic [bstx_pkg::PWORD_W-1:0]  pmem_rdata
);
    import bstx_pkg::*;
    logic [7:0] lo_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Low fetched byte, one cycle late, to match the memory write
    always_ff @(posedge sys_clk) begin
        lo_q <= pmem_rdata[7:0];
    end
    sequence s_take(bstx_op_t o);
        instr.valid && instr_ready && instr.op == o;
    endsequence
    a_skip_on_zero: assert property (s_take(BSTX_BIT_ZERO_SKIP_OP) ##0 !dmem_rdata[instr.bit_sel] |=>
        skip_next && !instr_ready ##1 instr_ready) else $error("skip missing");
    a_skip_on_one: assert property (s_take(BSTX_BIT_ZERO_SKIP_OP) ##0 dmem_rdata[instr.bit_sel] |=>
        !skip_next) else $error("stray skip");
    a_dummy_pair: assert property ((dummy_cycle == skip_next) && (!dummy_cycle || !instr_ready))
        else $error("dummy cycle unpaired");
    a_skip_no_wr: assert property (s_take(BSTX_BIT_ZERO_SKIP_OP) |=> !dmem_wr.we && !pmem_req)
        else $error("skip side effect");
    a_tbl_fetch: assert property (s_take(BSTX_TABLE_READ_OP) |=> pmem_req && !instr_ready ##1
        dmem_wr.we && dmem_wr.data == lo_q && dmem_wr.addr == $past(dmem_raddr, 2)) else $error("table read");
    a_last_page: assert property (s_take(BSTX_LAST_PAGE_TABLE_READ_OP) |=>
        pmem_req && pmem_addr[15:8] == LAST_PAGE) else $error("last page address");
    a_xmem_wr: assert property (s_take(BSTX_XOR_TO_MEMORY_OP) |=>
        dmem_wr.we && dmem_wr.addr == $past(dmem_raddr)) else $error("xor write back");
    a_xacc_no_wr: assert property ((s_take(BSTX_XOR_REG_OP) or s_take(BSTX_XOR_IMM_OP)) |=>
        !dmem_wr.we) else $error("xor wrote memory");
endmodule : bstx_chk

// ---- bench/bstx_tb_top.sv ----
`timescale 1ns/10ps
module bstx_tb_top;
    import bstx_pkg::*;
    logic sys_clk, rst, reg_wr, reg_rd, instr_ready, skip_next, dummy_cycle, pmem_req, sk, dm, rdy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dmem_raddr;
    // Operands are preloaded so the memory has one writer, the block's write port
    logic [7:0] mem [256] = '{8'h10: 8'h3c, 8'h20: 8'ha5, 8'h30: 8'h5a, default: 8'h00};
    logic [15:0] pmem_addr;
    bstx_instr_t instr;
    bstx_dwr_t dmem_wr;
    int n_fail, n_tests, cyc;
    bstx_core u_bstx_core (.sys_clk, .rst, .instr, .instr_ready, .skip_next, .dummy_cycle, .dmem_raddr,
        .dmem_rdata(mem[dmem_raddr]), .dmem_wr, .pmem_req, .pmem_addr,
        .pmem_rdata(pmem_req ? pmem_addr ^ 16'ha55a : ~pmem_addr), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    // Data memory takes the block's write pulses
    always @(posedge sys_clk) begin
        if (dmem_wr.we) mem[dmem_wr.addr] <= dmem_wr.data;
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // Issue one instruction, note the skip pulse, then let it finish
    task issue(input bstx_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] im);
        @(posedge sys_clk) instr <= '{1'b1, op, a, b, im};
        @(posedge sys_clk) instr.valid <= 1'b0;
        #1 {sk, dm, rdy} = {skip_next, dummy_cycle, instr_ready};
        repeat (3) @(posedge sys_clk);
    endtask : issue
    task t_xor;
        wr(OFF_FLAGS, 8'h83);
        wr(OFF_ACC, 8'h3c);
        issue(BSTX_XOR_REG_OP, 8'h10, 3'h0, 8'h00);
        rd(OFF_ACC, 8'h00);
        rd(OFF_FLAGS, 8'h87);
        issue(BSTX_XOR_IMM_OP, 8'h00, 3'h0, 8'ha5);
        rd(OFF_ACC, 8'ha5);
        rd(OFF_FLAGS, 8'h83);
        issue(BSTX_XOR_TO_MEMORY_OP, 8'h20, 3'h0, 8'h00);
        chk(mem[8'h20], 8'h00);
        rd(OFF_ACC, 8'ha5);
        rd(OFF_FLAGS, 8'h87);
        issue(BSTX_NOP, 8'h20, 3'h0, 8'h5a);
        rd(OFF_ACC, 8'ha5);
        chk(mem[8'h20], 8'h00);
    endtask : t_xor
    // Every bit position, both outcomes, flags left alone
    task t_skip;
        for (int i = 0; i < 8; i++) begin
            issue(BSTX_BIT_ZERO_SKIP_OP, 8'h30, 3'(i), 8'h00);
            chk({7'h0, sk}, {7'h0, ~mem[8'h30][i]});
            chk({7'h0, dm}, {7'h0, ~mem[8'h30][i]});
            chk({7'h0, rdy}, {7'h0, mem[8'h30][i]});
        end
        rd(OFF_FLAGS, 8'h87);
    endtask : t_skip
    task t_table;
        wr(OFF_TPH, 8'h12);
        wr(OFF_TPL, 8'h34);
        wr(OFF_TBH, 8'h99);
        rd(OFF_TBH, TBL_RST);
        issue(BSTX_TABLE_READ_OP, 8'h40, 3'h0, 8'h00);
        chk({7'h0, rdy}, 8'h00);
        chk(mem[8'h40], 8'h6e);
        rd(OFF_TBH, 8'hb7);
        issue(BSTX_LAST_PAGE_TABLE_READ_OP, 8'h41, 3'h0, 8'h00);
        chk(mem[8'h41], 8'h6e);
        rd(OFF_TBH, 8'h5a);
        rd(OFF_FLAGS, 8'h87);
    endtask : t_table
    task final_report;
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, instr} = '0;
        rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFF_ACC, ACC_RST);
        rd(OFF_TBH, TBL_RST);
        t_xor();
        t_skip();
        t_table();
        final_report();
    end
endmodule : bstx_tb_top
bind bstx_core bstx_chk u_bstx_chk (.sys_clk, .rst, .instr, .instr_ready, .skip_next, .dummy_cycle,
    .dmem_raddr, .dmem_rdata, .dmem_wr, .pmem_req, .pmem_addr, .pmem_rdata);
